/* File: hw/rif_pin_driver.sv */
// rif_pin_driver: turns the logical interrupt level into pin signals.
// assumes the pad resolves the wire from output and enable.
`timescale 1ns/1ps
module rif_pin_driver (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset,
  // control
  input  wire logic i_active,
  input  wire logic i_active_high,
  input  wire logic i_main_power,
  // pin
  output logic      o_pin_out,
  output logic      o_pin_oe
);

  logic out_r;
  logic oe_r;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      out_r <= 1'b0;
      oe_r  <= 1'b0;
    end else if (i_active_high) begin
      // push-pull, high only on main power
      out_r <= i_active & i_main_power;
      oe_r  <= 1'b1;
    end else begin
      // open drain: pull low when active, else release
      out_r <= 1'b0;
      oe_r  <= i_active;
    end
  end

  assign o_pin_out = out_r;
  assign o_pin_oe  = oe_r;

endmodule : rif_pin_driver

/* File: hw/rif_pkg.sv */
// rif_pkg: constants and types for the rtc interrupt and flag logic.
// assumes a 10 MHz core clock and a plain strobe register port.
//
// How it works
// - three sources, each with own enable bit
// - pin active only for flag with enable
// - pulse mode drives pin about 200 ms
// - level mode holds pin until flags read
// - flags read ends running pulse at once
// - no interrupts while on backup supply
// - timeout sets flag, pin only if enabled
// - alarm sets flag, pin only if enabled
// - supply loss sets flag, pin only if enabled
// - polarity one: high push-pull, else low open-drain
// - polarity and pulse bits in interrupt control
// - any flags read clears the three source flags
// - each event sets its own flag
// - flags reset to zero except crystal stop
// - control registers binary, time registers bcd
// - upper byte of clock registers reserved
// - alarm fields match time sets alarm flag
package rif_pkg;

  localparam logic [18:0] ADDR_EVENT_FLAGS   = 19'h7FFF0;
  localparam logic [18:0] ADDR_CENTURIES     = 19'h7FFF1;
  localparam logic [18:0] ADDR_ALARM_SECONDS = 19'h7FFF2;
  localparam logic [18:0] ADDR_ALARM_MINUTES = 19'h7FFF3;
  localparam logic [18:0] ADDR_ALARM_HOURS   = 19'h7FFF4;
  localparam logic [18:0] ADDR_ALARM_DATE    = 19'h7FFF5;
  localparam logic [18:0] ADDR_INT_CONTROL   = 19'h7FFF6;
  localparam logic [18:0] ADDR_WATCHDOG      = 19'h7FFF7;
  localparam logic [18:0] ADDR_CALIBRATION   = 19'h7FFF8;
  localparam logic [18:0] ADDR_SECONDS       = 19'h7FFF9;
  localparam logic [18:0] ADDR_MINUTES       = 19'h7FFFA;
  localparam logic [18:0] ADDR_HOURS         = 19'h7FFFB;
  localparam logic [18:0] ADDR_WEEKDAY       = 19'h7FFFC;
  localparam logic [18:0] ADDR_MONTH_DAY     = 19'h7FFFD;
  localparam logic [18:0] ADDR_MONTHS        = 19'h7FFFE;
  localparam logic [18:0] ADDR_YEARS         = 19'h7FFFF;

  // flags register fields
  localparam int FLG_TIMEOUT  = 7;
  localparam int FLG_ALARM    = 6;
  localparam int FLG_SUPPLY   = 5;
  localparam int FLG_CRYSTAL  = 4;
  localparam int FLG_CAL      = 2;
  localparam int FLG_WRITE    = 1;
  localparam int FLG_READ     = 0;
  // interrupt control fields
  localparam int ICR_TIMEOUT_EN = 7;
  localparam int ICR_ALARM_EN   = 6;
  localparam int ICR_SUPPLY_EN  = 5;
  localparam int ICR_POLARITY   = 3;
  localparam int ICR_PULSE      = 2;
  localparam logic [7:0] ICR_WRITE_MASK = 8'hEC;
  localparam logic [7:0] FLG_WRITE_MASK = 8'h17;
  // watchdog fields
  localparam int WDG_LOCK = 6;
  localparam logic [7:0] WDG_VALUE_MASK = 8'h3F;
  // alarm match-disable bit
  localparam int ALM_MATCH_OFF = 7;

  // reset values
  localparam logic [7:0] RST_FLAGS       = 8'h00;
  localparam logic [7:0] RST_INT_CONTROL = 8'h08;
  localparam logic [7:0] RST_ALARM       = 8'h80;
  localparam logic [7:0] RST_ZERO        = 8'h00;

  // pulse timing
  localparam int CLK_HZ         = 10_000_000;
  localparam int PULSE_TIME_MS  = 200;
  localparam int PULSE_CYCLES   = CLK_HZ / 1000 * PULSE_TIME_MS;
  localparam int PULSE_CNT_W    = 21;

  typedef enum logic [2:0] {
    PIN_IDLE  = 3'b001,
    PIN_PULSE = 3'b010,
    PIN_HELD  = 3'b100
  } rif_pin_state_type;

  // one event per source, same order as flag bits 7..5
  typedef struct packed {
    logic timeout;
    logic alarm;
    logic supply_loss;
  } rif_events_type;

  typedef struct packed {
    logic [18:0] addr;
    logic [15:0] wdata;
    logic        write;
    logic        read;
  } rif_bus_req_type;

endpackage : rif_pkg

/* File: hw/rif_top.sv */
// rif_top: flags, enables, interrupt pin and clock register map.
// assumes time keeping, watchdog counter and power monitor are outside
// and hand in one-cycle event pulses synchronous to the core clock.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module rif_top (
  // clock and reset
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RESET,
  // register port
  input  wire logic [18:0] I_ADDR,
  input  wire logic [15:0] I_WDATA,
  input  wire logic        I_WRITE,
  input  wire logic        I_READ,
  output logic      [15:0] O_RDATA,
  // event sources
  input  wire logic        I_TIMEOUT_EVENT,
  input  wire logic        I_SUPPLY_LOSS_EVENT,
  input  wire logic        I_CRYSTAL_STOP_EVENT,
  input  wire logic        I_MAIN_POWER,
  // current time from the counters, bcd
  input  wire logic [7:0]  I_TIME_SECONDS,
  input  wire logic [7:0]  I_TIME_MINUTES,
  input  wire logic [7:0]  I_TIME_HOURS,
  input  wire logic [7:0]  I_TIME_DATE,
  // control out to counters
  output logic             O_TIMEOUT_RESTART,
  output logic      [5:0]  O_TIMEOUT_VALUE,
  output logic             O_CRYSTAL_RUN,
  output logic      [5:0]  O_CAL_VALUE,
  output logic             O_CAL_SIGN,
  output logic             O_CAL_TEST,
  output logic             O_READ_HOLD,
  // interrupt pin
  output logic             O_INT_OUT,
  output logic             O_INT_OE
);

  ////////////////////////////////////////////////////////////////////
  // register storage

  rif_pkg::rif_bus_req_type req;
  rif_pkg::rif_events_type  evt;
  rif_pkg::rif_pin_state_type pin_state_r;

  logic [7:0] flags_r;
  logic [7:0] int_control_r;
  logic [7:0] watchdog_r;
  logic [7:0] calibration_r;
  logic [7:0] alarm_r [0:3];
  logic [7:0] clock_r [0:6];
  logic [7:0] rdata_r;
  logic       restart_r;
  logic [rif_pkg::PULSE_CNT_W-1:0] pulse_cnt_r;
  logic       alarm_hit;
  logic       alarm_match_prev_r;
  logic       alarm_match;
  logic       flags_read;
  logic       flags_write;
  logic       pending;
  logic       raise;
  logic       pin_active;
  logic [2:0] enabled_hits;

  assign req = '{addr: I_ADDR, wdata: I_WDATA, write: I_WRITE, read: I_READ};
  assign flags_read  = req.read & (req.addr == rif_pkg::ADDR_EVENT_FLAGS);
  assign flags_write = req.write & (req.addr == rif_pkg::ADDR_EVENT_FLAGS)
                       & flags_r[rif_pkg::FLG_WRITE];

  ////////////////////////////////////////////////////////////////////
  // alarm match: fields with match-disable clear are compared

  logic [3:0] field_ok;
  logic [7:0] time_now [0:3];
  assign time_now[0] = I_TIME_SECONDS;
  assign time_now[1] = I_TIME_MINUTES;
  assign time_now[2] = I_TIME_HOURS;
  assign time_now[3] = I_TIME_DATE;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_match
      assign field_ok[g] = alarm_r[g][rif_pkg::ALM_MATCH_OFF]
                           | (alarm_r[g][6:0] == time_now[g][6:0]);
    end
  endgenerate

  // all fields disabled means alarm off; edge so one match sets once
  assign alarm_match = (&field_ok) & ~(&{alarm_r[0][7], alarm_r[1][7],
                                         alarm_r[2][7], alarm_r[3][7]});
  assign alarm_hit = alarm_match & ~alarm_match_prev_r;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      alarm_match_prev_r <= 1'b0;
    end else begin
      alarm_match_prev_r <= alarm_match;
    end
  end

  assign evt = '{timeout: I_TIMEOUT_EVENT, alarm: alarm_hit,
                 supply_loss: I_SUPPLY_LOSS_EVENT};

  ////////////////////////////////////////////////////////////////////
  // flags register

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      flags_r[7:5] <= 3'h0;
      flags_r[4:0] <= 5'h00;
    end else begin
      // source flags: read clears, a coincident event still sets
      if (flags_read) begin
        flags_r[7:5] <= evt;
      end else begin
        flags_r[7:5] <= flags_r[7:5] | evt;
      end
      if (flags_write) begin
        flags_r[rif_pkg::FLG_CAL]   <= req.wdata[rif_pkg::FLG_CAL];
        flags_r[rif_pkg::FLG_READ]  <= req.wdata[rif_pkg::FLG_READ];
      end
      // the write-enable bit itself is always writable
      if (req.write && req.addr == rif_pkg::ADDR_EVENT_FLAGS) begin
        flags_r[rif_pkg::FLG_WRITE] <= req.wdata[rif_pkg::FLG_WRITE];
      end
      flags_r[4:3] <= 2'h0;
    end
  end

  // crystal stop flag is not touched by reset, only by its event or a write
  logic crystal_stop_r;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_CRYSTAL_STOP_EVENT) begin
      crystal_stop_r <= 1'b1;
    end else if (flags_write) begin
      crystal_stop_r <= req.wdata[rif_pkg::FLG_CRYSTAL];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control registers, binary

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      int_control_r <= rif_pkg::RST_INT_CONTROL;
      watchdog_r    <= rif_pkg::RST_ZERO;
      calibration_r <= rif_pkg::RST_ZERO;
      restart_r     <= 1'b0;
    end else begin
      restart_r <= 1'b0;
      if (req.write && req.addr == rif_pkg::ADDR_INT_CONTROL) begin
        int_control_r <= req.wdata[7:0] & rif_pkg::ICR_WRITE_MASK;
      end
      if (req.write && req.addr == rif_pkg::ADDR_WATCHDOG) begin
        watchdog_r[rif_pkg::WDG_LOCK] <= req.wdata[rif_pkg::WDG_LOCK];
        restart_r <= req.wdata[7];
        if (!req.wdata[rif_pkg::WDG_LOCK]) begin
          watchdog_r[5:0] <= req.wdata[5:0];
        end
      end
      if (req.write && req.addr == rif_pkg::ADDR_CALIBRATION) begin
        calibration_r <= req.wdata[7:0] & 8'hBF;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // alarm and clock registers, bcd; alarm writes need the write bit

  generate
    for (g = 0; g < 4; g++) begin : g_alarm
      always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
          alarm_r[g] <= rif_pkg::RST_ALARM;
        end else if (req.write && flags_r[rif_pkg::FLG_WRITE]
                     && req.addr == rif_pkg::ADDR_ALARM_SECONDS + 19'(g)) begin
          alarm_r[g] <= req.wdata[7:0];
        end
      end
    end
    for (g = 0; g < 7; g++) begin : g_clock
      always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
          clock_r[g] <= rif_pkg::RST_ZERO;
        end else if (req.write && req.addr == rif_pkg::ADDR_SECONDS + 19'(g)) begin
          clock_r[g] <= req.wdata[7:0];
        end
      end
    end
  endgenerate

  logic [7:0] centuries_r;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      centuries_r <= rif_pkg::RST_ZERO;
    end else if (req.write && req.addr == rif_pkg::ADDR_CENTURIES) begin
      centuries_r <= req.wdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read port, one cycle latency, upper byte reserved

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      rdata_r <= rif_pkg::RST_ZERO;
    end else if (req.read) begin
      if (req.addr == rif_pkg::ADDR_EVENT_FLAGS) begin
        rdata_r <= {flags_r[7:5], crystal_stop_r, flags_r[3:0]};
      end else if (req.addr == rif_pkg::ADDR_CENTURIES) begin
        rdata_r <= centuries_r;
      end else if (req.addr >= rif_pkg::ADDR_ALARM_SECONDS
                   && req.addr <= rif_pkg::ADDR_ALARM_DATE) begin
        rdata_r <= alarm_r[2'(req.addr - rif_pkg::ADDR_ALARM_SECONDS)];
      end else if (req.addr == rif_pkg::ADDR_INT_CONTROL) begin
        rdata_r <= int_control_r;
      end else if (req.addr == rif_pkg::ADDR_WATCHDOG) begin
        rdata_r <= {1'b0, watchdog_r[6:0]};
      end else if (req.addr == rif_pkg::ADDR_CALIBRATION) begin
        rdata_r <= calibration_r;
      end else if (req.addr >= rif_pkg::ADDR_SECONDS) begin
        rdata_r <= clock_r[3'(req.addr - rif_pkg::ADDR_SECONDS)];
      end else begin
        rdata_r <= rif_pkg::RST_ZERO;
      end
    end else begin
      rdata_r <= rif_pkg::RST_ZERO;
    end
  end

  assign O_RDATA = {8'h00, rdata_r};

  ////////////////////////////////////////////////////////////////////
  // interrupt pin sequencing

  assign enabled_hits = flags_r[7:5] & {int_control_r[rif_pkg::ICR_TIMEOUT_EN],
                                        int_control_r[rif_pkg::ICR_ALARM_EN],
                                        int_control_r[rif_pkg::ICR_SUPPLY_EN]};
  // new enabled event this cycle starts a pulse
  assign raise   = |(evt & {int_control_r[rif_pkg::ICR_TIMEOUT_EN],
                            int_control_r[rif_pkg::ICR_ALARM_EN],
                            int_control_r[rif_pkg::ICR_SUPPLY_EN]});
  assign pending = |enabled_hits;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      pin_state_r <= rif_pkg::PIN_IDLE;
      pulse_cnt_r <= '0;
    end else if (!I_MAIN_POWER) begin
      pin_state_r <= rif_pkg::PIN_IDLE;
      pulse_cnt_r <= '0;
    end else begin
      case (pin_state_r)
        rif_pkg::PIN_IDLE: begin
          if (int_control_r[rif_pkg::ICR_PULSE] && raise && !flags_read) begin
            pin_state_r <= rif_pkg::PIN_PULSE;
            pulse_cnt_r <= rif_pkg::PULSE_CNT_W'(rif_pkg::PULSE_CYCLES - 1);
          end else if (!int_control_r[rif_pkg::ICR_PULSE] && pending && !flags_read) begin
            pin_state_r <= rif_pkg::PIN_HELD;
          end
        end
        rif_pkg::PIN_PULSE: begin
          if (flags_read) begin
            pin_state_r <= rif_pkg::PIN_IDLE;
          end else if (pulse_cnt_r == '0) begin
            pin_state_r <= rif_pkg::PIN_IDLE;
          end else begin
            pulse_cnt_r <= pulse_cnt_r - 1'b1;
          end
        end
        rif_pkg::PIN_HELD: begin
          if (flags_read || !pending || int_control_r[rif_pkg::ICR_PULSE]) begin
            pin_state_r <= rif_pkg::PIN_IDLE;
          end
        end
        default: begin
          pin_state_r <= rif_pkg::PIN_IDLE;
        end
      endcase
    end
  end

  assign pin_active = (pin_state_r != rif_pkg::PIN_IDLE);

  rif_pin_driver u_pin (
    .i_clk         (I_CORE_CLK),
    .i_reset       (I_RESET),
    .i_active      (pin_active),
    .i_active_high (int_control_r[rif_pkg::ICR_POLARITY]),
    .i_main_power  (I_MAIN_POWER),
    .o_pin_out     (O_INT_OUT),
    .o_pin_oe      (O_INT_OE)
  );

  ////////////////////////////////////////////////////////////////////
  // control outputs to the counters

  assign O_TIMEOUT_RESTART = restart_r;
  assign O_TIMEOUT_VALUE   = watchdog_r[5:0];
  assign O_CRYSTAL_RUN     = ~calibration_r[7];
  assign O_CAL_VALUE       = {1'b0, calibration_r[4:0]};
  assign O_CAL_SIGN        = calibration_r[5];
  assign O_CAL_TEST        = flags_r[rif_pkg::FLG_CAL];
  assign O_READ_HOLD       = flags_r[rif_pkg::FLG_READ];

endmodule : rif_top

/* File: test/rif_host_model.sv */
// rif_host_model: host side, register master and interrupt wire reader.
// assumes one clock and a pull-up on the interrupt wire.
`timescale 1ns/1ps
module rif_host_model #(
  parameter int RESTORE_CYCLES = 8
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // register port
  output logic      [18:0] o_addr,
  output logic      [15:0] o_wdata,
  output logic             o_write,
  output logic             o_read,
  input  wire logic [15:0] i_rdata,
  // interrupt wire
  input  wire logic        i_int_out,
  input  wire logic        i_int_oe,
  output logic             o_int_wire,
  output logic             o_restored
);
  int restore_cnt;
  // a released wire floats to the pull-up level
  assign o_int_wire = i_int_oe ? i_int_out : 1'b1;
  // pin activity is disregarded until the restore interval has run out
  always_ff @(posedge i_clk) begin
    if (i_reset) restore_cnt <= 0;
    else if (restore_cnt < RESTORE_CYCLES) restore_cnt <= restore_cnt + 1;
  end
  assign o_restored = restore_cnt >= RESTORE_CYCLES;
  initial begin
    o_addr  = 19'h00000;
    o_wdata = 16'h0000;
    o_write = 1'b0;
    o_read  = 1'b0;
  end
  // upper byte is set to show it is ignored
  task automatic reg_wr(input logic [18:0] a, input logic [7:0] d);
    o_addr  <= a;
    o_wdata <= {8'hFF, d};
    o_write <= 1'b1;
    @(posedge i_clk);
    o_write <= 1'b0;
    @(posedge i_clk);
  endtask : reg_wr
  task automatic reg_rd(input logic [18:0] a, output logic [15:0] d);
    o_addr <= a;
    o_read <= 1'b1;
    @(posedge i_clk);
    o_read <= 1'b0;
    @(posedge i_clk);
    d = i_rdata;
  endtask : reg_rd
  // flags and alarm writes are opened, made, then closed again
  task automatic locked_wr(input logic [18:0] a, input logic [7:0] d);
    reg_wr(rif_pkg::ADDR_EVENT_FLAGS, 8'h02);
    reg_wr(a, d);
    reg_wr(rif_pkg::ADDR_EVENT_FLAGS, 8'h00);
  endtask : locked_wr
endmodule : rif_host_model

/* File: test/rif_top_asserts.sv */
// rif_top_asserts: port-level checks of the interrupt and flag logic.
// assumes it is bound to rif_top and sees only that module's ports.
`timescale 1ns/1ps
module rif_top_asserts (
  // clock, reset, register port
  input wire logic        I_CORE_CLK,
  input wire logic        I_RESET,
  input wire logic [18:0] I_ADDR,
  input wire logic [15:0] I_WDATA,
  input wire logic        I_WRITE,
  input wire logic        I_READ,
  input wire logic [15:0] O_RDATA,
  // events and pin
  input wire logic        I_TIMEOUT_EVENT,
  input wire logic        I_SUPPLY_LOSS_EVENT,
  input wire logic        I_MAIN_POWER,
  input wire logic        O_INT_OUT,
  input wire logic        O_INT_OE
);
  logic [7:0] icr_r;
  logic [2:0] settle_r;
  logic       main_d_r;
  logic       icr_wr;
  logic       flags_rd;
  logic       ready;
  logic       hi_lvl;
  logic       hi_pls;
  assign icr_wr   = I_WRITE && I_ADDR == rif_pkg::ADDR_INT_CONTROL;
  assign flags_rd = I_READ && I_ADDR == rif_pkg::ADDR_EVENT_FLAGS;
  assign ready    = settle_r >= 3'h4 && I_MAIN_POWER && icr_r[rif_pkg::ICR_POLARITY];
  assign hi_lvl   = ready && !icr_r[rif_pkg::ICR_PULSE];
  assign hi_pls   = ready && icr_r[rif_pkg::ICR_PULSE];
  // shadow of the interrupt control register
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) icr_r <= rif_pkg::RST_INT_CONTROL;
    else if (icr_wr) icr_r <= I_WDATA[7:0] & rif_pkg::ICR_WRITE_MASK;
  end
  // cycles since the pin setup last changed
  always_ff @(posedge I_CORE_CLK) begin
    main_d_r <= I_MAIN_POWER;
    if (I_RESET || icr_wr || main_d_r != I_MAIN_POWER) settle_r <= 3'h0;
    else if (settle_r != 3'h7) settle_r <= settle_r + 3'h1;
  end
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RESET);
  ////////////////////////////////////////////////////////////////////////////
  a_upper_reserved: assert property (O_RDATA[15:8] == 8'h00)
    else $error("upper read byte not zero");
  a_icr_readback: assert property (I_READ && I_ADDR == rif_pkg::ADDR_INT_CONTROL
    |=> O_RDATA[7:0] == $past(icr_r)) else $error("interrupt control readback wrong");
  a_od_never_high: assert property (settle_r >= 3'h4 && !icr_r[rif_pkg::ICR_POLARITY]
    |-> !O_INT_OUT) else $error("open drain pin driven high");
  a_backup_quiet: assert property (settle_r >= 3'h4 && !I_MAIN_POWER
    |-> !O_INT_OUT && (icr_r[rif_pkg::ICR_POLARITY] || !O_INT_OE))
    else $error("pin active on backup supply");
  a_level_raise: assert property (hi_lvl && icr_r[rif_pkg::ICR_TIMEOUT_EN]
    && I_TIMEOUT_EVENT && !I_READ ##1 !I_READ |-> ##2 O_INT_OUT)
    else $error("enabled timeout did not raise pin");
  a_pulse_raise: assert property (hi_pls && icr_r[rif_pkg::ICR_SUPPLY_EN]
    && I_SUPPLY_LOSS_EVENT && !I_READ ##1 !I_READ |-> ##1 O_INT_OUT [*2])
    else $error("enabled supply loss did not start pulse");
  a_read_drops: assert property (ready && flags_rd && !I_TIMEOUT_EVENT
    && !I_SUPPLY_LOSS_EVENT |-> ##2 !O_INT_OUT) else $error("flags read left pin active");
  a_disabled_quiet: assert property (hi_lvl && icr_r[7:5] == 3'h0 |-> !O_INT_OUT)
    else $error("pin active with no enable");
  cover property (hi_pls && I_SUPPLY_LOSS_EVENT);
  cover property (ready && flags_rd && O_INT_OUT);
  cover property (!I_MAIN_POWER && I_TIMEOUT_EVENT);
endmodule : rif_top_asserts

bind rif_top rif_top_asserts rif_top_asserts_inst (.I_CORE_CLK, .I_RESET, .I_ADDR, .I_WDATA,
  .I_WRITE, .I_READ, .O_RDATA, .I_TIMEOUT_EVENT, .I_SUPPLY_LOSS_EVENT, .I_MAIN_POWER,
  .O_INT_OUT, .O_INT_OE);

/* File: test/tb_rif_top.sv */
// tb_rif_top: self-checking bench for the interrupt and flag logic.
// assumes rif_top, rif_host_model and the bound checker are compiled.
`timescale 1ns/1ps
module tb_rif_top;
  logic        clk;
  logic        rst;
  logic [18:0] addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        ev_to;
  logic        ev_sl;
  logic        main_pwr;
  logic [7:0]  t_sec;
  logic [5:0]  tval;
  logic        restart;
  logic        crys_run;
  logic [5:0]  cal_val;
  logic        cal_sign;
  logic        cal_test;
  logic        rd_hold;
  logic        int_out;
  logic        int_oe;
  logic        int_wire;
  logic        restored;
  logic [15:0] d;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          restart_cnt = 0;
  rif_top rif_top_inst (.I_CORE_CLK(clk), .I_RESET(rst), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WRITE(wr), .I_READ(rd), .O_RDATA(rdata), .I_TIMEOUT_EVENT(ev_to),
    .I_SUPPLY_LOSS_EVENT(ev_sl), .I_CRYSTAL_STOP_EVENT(1'b0), .I_MAIN_POWER(main_pwr),
    .I_TIME_SECONDS(t_sec), .I_TIME_MINUTES(8'h00), .I_TIME_HOURS(8'h00),
    .I_TIME_DATE(8'h01), .O_TIMEOUT_RESTART(restart), .O_TIMEOUT_VALUE(tval),
    .O_CRYSTAL_RUN(crys_run), .O_CAL_VALUE(cal_val), .O_CAL_SIGN(cal_sign),
    .O_CAL_TEST(cal_test), .O_READ_HOLD(rd_hold), .O_INT_OUT(int_out),
    .O_INT_OE(int_oe));
  rif_host_model rif_host_model_inst (.i_clk(clk), .i_reset(rst), .o_addr(addr),
    .o_wdata(wdata), .o_write(wr), .o_read(rd), .i_rdata(rdata), .i_int_out(int_out),
    .i_int_oe(int_oe), .o_int_wire(int_wire), .o_restored(restored));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  task automatic pin_is(input logic v);
    check({15'h0000, int_wire}, {15'h0000, v});
  endtask : pin_is
  task automatic rdf(input logic [18:0] a);
    rif_host_model_inst.reg_rd(a, d);
  endtask : rdf
  task automatic wrr(input logic [18:0] a, input logic [7:0] v);
    rif_host_model_inst.reg_wr(a, v);
  endtask : wrr
  // one-cycle events, then time for the pin to settle
  task automatic ev(input logic [1:0] m);
    {ev_to, ev_sl} <= m;
    @(posedge clk);
    {ev_to, ev_sl} <= 2'b00;
    repeat (5) @(posedge clk);
  endtask : ev
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_map;
    rdf(rif_pkg::ADDR_INT_CONTROL);
    check(d, 16'h0008);
    rdf(rif_pkg::ADDR_ALARM_DATE);
    check(d, 16'h0080);
    rdf(rif_pkg::ADDR_EVENT_FLAGS);
    check(d & 16'hFFEF, 16'h0000);
    rdf(19'h00010);
    check(d, 16'h0000);
    wrr(rif_pkg::ADDR_WATCHDOG, 8'h05);
    wrr(rif_pkg::ADDR_WATCHDOG, 8'h4A);
    check({10'h000, tval}, 16'h0005);
    wrr(rif_pkg::ADDR_WATCHDOG, 8'hC0);
    check(16'(restart_cnt), 16'h0001);
    rdf(rif_pkg::ADDR_WATCHDOG);
    check(d, 16'h0045);
    wrr(rif_pkg::ADDR_CALIBRATION, 8'hA5);
    check({8'h00, crys_run, cal_sign, cal_val}, 16'h0045);
    rdf(rif_pkg::ADDR_CALIBRATION);
    check(d, 16'h00A5);
    rif_host_model_inst.locked_wr(rif_pkg::ADDR_EVENT_FLAGS, 8'h05);
    check({14'h0000, cal_test, rd_hold}, 16'h0003);
    rif_host_model_inst.locked_wr(rif_pkg::ADDR_EVENT_FLAGS, 8'h00);
    wrr(rif_pkg::ADDR_EVENT_FLAGS, 8'h05);
    check({14'h0000, cal_test, rd_hold}, 16'h0000);
    rif_host_model_inst.locked_wr(rif_pkg::ADDR_ALARM_SECONDS, 8'h05);
  endtask : t_map
  task automatic t_silent;
    ev(2'b10);
    ev(2'b01);
    t_sec <= 8'h05;
    repeat (5) @(posedge clk);
    pin_is(1'b0);
    rdf(rif_pkg::ADDR_EVENT_FLAGS);
    check(d, 16'h00E0);
    rdf(rif_pkg::ADDR_EVENT_FLAGS);
    check(d, 16'h0000);
  endtask : t_silent
  task automatic t_level;
    wrr(rif_pkg::ADDR_INT_CONTROL, 8'hA8);
    repeat (4) @(posedge clk);
    ev(2'b10);
    pin_is(1'b1);
    ev(2'b01);
    fork
      rdf(rif_pkg::ADDR_EVENT_FLAGS);
      begin
        ev_to <= 1'b1;
        @(posedge clk);
        ev_to <= 1'b0;
      end
    join
    check(d, 16'h00A0);
    repeat (4) @(posedge clk);
    pin_is(1'b1);
    rdf(rif_pkg::ADDR_EVENT_FLAGS);
    check(d, 16'h0080);
    repeat (2) @(posedge clk);
    pin_is(1'b0);
  endtask : t_level
  task automatic t_pulse;
    wrr(rif_pkg::ADDR_INT_CONTROL, 8'h2C);
    repeat (4) @(posedge clk);
    ev(2'b01);
    repeat (200) @(posedge clk);
    pin_is(1'b1);
    rdf(rif_pkg::ADDR_EVENT_FLAGS);
    check(d, 16'h0020);
    repeat (2) @(posedge clk);
    pin_is(1'b0);
  endtask : t_pulse
  task automatic t_open_drain;
    wrr(rif_pkg::ADDR_INT_CONTROL, 8'h80);
    repeat (4) @(posedge clk);
    pin_is(1'b1);
    ev(2'b10);
    pin_is(1'b0);
    rdf(rif_pkg::ADDR_EVENT_FLAGS);
    repeat (2) @(posedge clk);
    pin_is(1'b1);
  endtask : t_open_drain
  // open drain, so a pin state left active would pull the wire low
  task automatic t_backup;
    wrr(rif_pkg::ADDR_INT_CONTROL, 8'hA0);
    main_pwr <= 1'b0;
    repeat (4) @(posedge clk);
    ev(2'b10);
    pin_is(1'b1);
    rdf(rif_pkg::ADDR_EVENT_FLAGS);
    check(d, 16'h0080);
    main_pwr <= 1'b1;
    repeat (4) @(posedge clk);
    pin_is(1'b1);
  endtask : t_backup
  ////////////////////////////////////////////////////////////////////////////
  always #50 clk = ~clk;
  // restart strobe counted mid-cycle, where it is settled
  always @(negedge clk) begin
    if (restart === 1'b1) begin
      restart_cnt++;
    end
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    ev_to = 1'b0;
    ev_sl = 1'b0;
    main_pwr = 1'b1;
    t_sec = 8'h00;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk iff restored);
    t_map();
    t_silent();
    t_level();
    t_pulse();
    t_open_drain();
    t_backup();
    results();
  end
endmodule : tb_rif_top
